// file: logic/retimer_channel_pkg.sv
// Offsets, field positions and reset values of the retimer channel register bank.
`default_nettype none
package retimer_channel_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] CHANNEL_RESET_CONTROL   = 8'h00;
    localparam logic [7:0] CHANNEL_LINK_STATUS     = 8'h01;
    localparam logic [7:0] SELECTABLE_STATUS_WORD  = 8'h02;
    localparam logic [7:0] EQUALISER_BOOST_FORCE   = 8'h03;
    localparam logic [7:0] RESERVED_REG_4          = 8'h04;
    localparam logic [7:0] RESERVED_REG_8          = 8'h08;
    localparam logic [7:0] LOOP_OVERRIDE_ENABLES   = 8'h09;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CORE_CLOCK_DISABLE_BIT = 7;
    localparam int CORE_RESET_BIT         = 3;
    localparam int REGS_RESET_BIT         = 2;
    localparam int ALL_COUNTERS_RESET_BIT = 1;
    localparam int FREQ_OFFSET_RESET_BIT  = 0;
    localparam int SIGNAL_PRESENT_BIT     = 7;
    localparam int POLARITY_INV_BIT       = 6;
    localparam int LOCK_LOSS_BIT          = 5;
    localparam int PRBS_LOCK_LSB          = 1;
    localparam int SIGNAL_LOSS_BIT        = 0;
    localparam int VCO_CAP_OV_BIT         = 7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] CONTROL_RESET_VALUE  = 8'h00;
    localparam logic [7:0] BOOST_RESET_VALUE    = 8'h00;
    localparam logic [7:0] RESERVED_RESET_VALUE = 8'h01;
    localparam logic [7:0] RESERVED_8_RESET     = 8'h60;
    localparam logic [7:0] OVERRIDE_RESET_VALUE = 8'h00;
    localparam logic [7:0] READ_ZERO            = 8'h00;

    // ****************************************************************
    // Writable storage: offsets 0x03 to 0x09 in one array
    // ****************************************************************
    localparam int STORE_FIRST = 3;
    localparam int STORE_COUNT = 7;
endpackage
`default_nettype wire

// file: logic/sticky_loss_flag.sv
// Sticky flag that records loss of a level after it was once acquired.
`timescale 1ns/1ns
`default_nettype none
module sticky_loss_flag
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_b,
    // Observed level and clears.
    input  wire logic level,
    input  wire logic clear_read,
    input  wire logic clear_all,
    // Flag.
    output logic      flag
);
    logic acquired;
    logic level_d;
    logic next_acquired;
    logic next_flag;
    logic lost;

    // A loss is a falling level once the level has been acquired.
    always_comb
    begin
        lost          = acquired && level_d && !level;
        next_acquired = acquired || level;
        next_flag     = flag;
        if (clear_read)
        begin
            next_flag = 1'b0;
        end
        // Set wins over a read clear in the same cycle.
        if (lost)
        begin
            next_flag = 1'b1;
        end
        if (clear_all)
        begin
            next_acquired = 1'b0;
            next_flag     = 1'b0;
        end
    end

    // Registers for the flag state.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acquired <= 1'b0;
            level_d  <= 1'b0;
            flag     <= 1'b0;
        end
        else
        begin
            acquired <= next_acquired;
            level_d  <= level;
            flag     <= next_flag;
        end
    end
endmodule
`default_nettype wire

// file: logic/retimer_channel_ctrl_status_regs.sv
// Per-channel control and status register bank of a serial retimer channel.
`timescale 1ns/1ns
`default_nettype none
module retimer_channel_ctrl_status_regs
#(
    parameter int CHANNEL_INDEX = 0,
    parameter int CHANNELS      = 16
)
(
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // Register access from the serial management slave.
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [7:0]            reg_rdata,
    output logic                       reg_rdata_valid,
    // Shared page selection.
    input  wire logic                  channel_page_select,
    input  wire logic [CHANNELS-1:0]   channel_enable,
    // Channel status sources.
    input  wire logic                  signal_present,
    input  wire logic                  polarity_inverted_flag,
    input  wire logic                  cdr_locked,
    input  wire logic                  prbs31_locked,
    input  wire logic                  prbs15_locked,
    input  wire logic                  prbs9_locked,
    input  wire logic                  prbs7_locked,
    input  wire logic [3:0]            status_view_select,
    input  wire logic [16*8-1:0]       status_words,
    // Equaliser boost force.
    input  wire logic                  eq_force_enable,
    output logic                       eq_boost_forced,
    output logic      [1:0]            eq_stage_a_boost,
    output logic      [1:0]            eq_stage_b_boost,
    output logic      [1:0]            eq_stage_c_boost,
    output logic      [1:0]            eq_stage_d_boost,
    // VCO capacitor count selection.
    input  wire logic [4:0]            vco_cap_internal,
    input  wire logic [4:0]            vco_cap_override_value,
    output logic      [4:0]            vco_cap_count,
    // Core controls.
    output logic                       core_clock_disable,
    output logic                       core_sm_reset,
    output logic                       all_sm_reset,
    output logic                       freq_offset_counter_reset,
    output logic                       eye_monitor_counter_reset,
    output logic                       lock_detect_counter_reset,
    output logic                       band_tune_counter_reset
);
    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0] control;
    logic [7:0] store      [retimer_channel_pkg::STORE_COUNT];
    logic [7:0] next_control;
    logic [7:0] next_store [retimer_channel_pkg::STORE_COUNT];
    logic [7:0] next_rdata;
    logic       selected;
    logic       access_write;
    logic       access_read;
    logic       regs_reset;
    logic       status_read;
    logic       lock_loss_flag;
    logic       signal_loss_flag;
    logic [7:0] link_status;

    // Reset value of one writable storage slot.
    function automatic logic [7:0] store_default(input int slot);
        if (slot == 0)
        begin
            return retimer_channel_pkg::BOOST_RESET_VALUE;
        end
        else if (slot == int'(retimer_channel_pkg::RESERVED_REG_8) - retimer_channel_pkg::STORE_FIRST)
        begin
            return retimer_channel_pkg::RESERVED_8_RESET;
        end
        else if (slot == retimer_channel_pkg::STORE_COUNT - 1)
        begin
            return retimer_channel_pkg::OVERRIDE_RESET_VALUE;
        end
        return retimer_channel_pkg::RESERVED_RESET_VALUE;
    endfunction

    // Selects one byte out of the packed status word bus.
    function automatic logic [7:0] pick_word(input logic [16*8-1:0] words,
                                             input logic [3:0] sel);
        return words[sel*8 +: 8];
    endfunction

    // ****************************************************************
    // Access decode
    // ****************************************************************
    // page and channel gate
    assign selected     = channel_page_select && channel_enable[CHANNEL_INDEX];
    assign access_write = reg_write && selected;
    assign access_read  = reg_read && selected;
    assign regs_reset   = control[retimer_channel_pkg::REGS_RESET_BIT];
    assign status_read  = access_read && (reg_addr == retimer_channel_pkg::CHANNEL_LINK_STATUS);

    // Lock loss flag: set on loss of acquired CDR lock, cleared by a status read.
    sticky_loss_flag u_lock_loss
    (
        .clk        (clk),
        .rst_b      (rst_b),
        .level      (cdr_locked),
        .clear_read (status_read),
        .clear_all  (regs_reset),
        .flag       (lock_loss_flag)
    );

    // Signal loss flag: set when an acquired input signal disappears.
    sticky_loss_flag u_signal_loss
    (
        .clk        (clk),
        .rst_b      (rst_b),
        .level      (signal_present),
        .clear_read (status_read),
        .clear_all  (regs_reset),
        .flag       (signal_loss_flag)
    );

    assign link_status = {signal_present, polarity_inverted_flag, lock_loss_flag,
                          prbs31_locked, prbs15_locked, prbs9_locked, prbs7_locked,
                          signal_loss_flag};

    // ****************************************************************
    // Register writes and reads
    // ****************************************************************
    // Next register contents and read data.
    always_comb
    begin
        next_control = control;
        next_store   = store;
        next_rdata   = reg_rdata;
        if (access_write)
        begin
            if (reg_addr == retimer_channel_pkg::CHANNEL_RESET_CONTROL)
            begin
                next_control = reg_wdata;
            end
            for (int i = 0; i < retimer_channel_pkg::STORE_COUNT; i++)
            begin
                if (int'(reg_addr) == i + retimer_channel_pkg::STORE_FIRST)
                begin
                    next_store[i] = reg_wdata;
                end
            end
        end
        if (regs_reset)
        begin
            next_control = retimer_channel_pkg::CONTROL_RESET_VALUE;
            for (int i = 0; i < retimer_channel_pkg::STORE_COUNT; i++)
            begin
                next_store[i] = store_default(i);
            end
        end
        if (access_read)
        begin
            next_rdata = retimer_channel_pkg::READ_ZERO;
            if (reg_addr == retimer_channel_pkg::CHANNEL_RESET_CONTROL)
            begin
                next_rdata = control;
            end
            else if (reg_addr == retimer_channel_pkg::CHANNEL_LINK_STATUS)
            begin
                next_rdata = link_status;
            end
            else if (reg_addr == retimer_channel_pkg::SELECTABLE_STATUS_WORD)
            begin
                next_rdata = pick_word(status_words, status_view_select);
            end
            for (int i = 0; i < retimer_channel_pkg::STORE_COUNT; i++)
            begin
                if (int'(reg_addr) == i + retimer_channel_pkg::STORE_FIRST)
                begin
                    next_rdata = store[i];
                end
            end
        end
    end

    // Register state and registered control outputs.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            control                   <= retimer_channel_pkg::CONTROL_RESET_VALUE;
            for (int i = 0; i < retimer_channel_pkg::STORE_COUNT; i++)
            begin
                store[i] <= store_default(i);
            end
            reg_rdata                 <= retimer_channel_pkg::READ_ZERO;
            reg_rdata_valid           <= 1'b0;
            core_clock_disable        <= 1'b0;
            core_sm_reset             <= 1'b0;
            all_sm_reset              <= 1'b0;
            freq_offset_counter_reset <= 1'b0;
            eye_monitor_counter_reset <= 1'b0;
            lock_detect_counter_reset <= 1'b0;
            band_tune_counter_reset   <= 1'b0;
            eq_boost_forced           <= 1'b0;
            eq_stage_a_boost          <= 2'h0;
            eq_stage_b_boost          <= 2'h0;
            eq_stage_c_boost          <= 2'h0;
            eq_stage_d_boost          <= 2'h0;
            vco_cap_count             <= 5'h00;
        end
        else
        begin
            control         <= next_control;
            store           <= next_store;
            reg_rdata       <= next_rdata;
            reg_rdata_valid <= access_read;
            core_clock_disable <= control[retimer_channel_pkg::CORE_CLOCK_DISABLE_BIT];
            all_sm_reset       <= control[retimer_channel_pkg::CORE_CLOCK_DISABLE_BIT];
            core_sm_reset      <= control[retimer_channel_pkg::CORE_RESET_BIT]
                                  || control[retimer_channel_pkg::CORE_CLOCK_DISABLE_BIT];
            freq_offset_counter_reset <= control[retimer_channel_pkg::FREQ_OFFSET_RESET_BIT]
                                         || control[retimer_channel_pkg::ALL_COUNTERS_RESET_BIT];
            eye_monitor_counter_reset <= control[retimer_channel_pkg::ALL_COUNTERS_RESET_BIT];
            lock_detect_counter_reset <= control[retimer_channel_pkg::ALL_COUNTERS_RESET_BIT];
            band_tune_counter_reset   <= control[retimer_channel_pkg::ALL_COUNTERS_RESET_BIT];
            eq_boost_forced  <= eq_force_enable;
            eq_stage_a_boost <= eq_force_enable ? store[0][7:6] : 2'h0;
            eq_stage_b_boost <= eq_force_enable ? store[0][5:4] : 2'h0;
            eq_stage_c_boost <= eq_force_enable ? store[0][3:2] : 2'h0;
            eq_stage_d_boost <= eq_force_enable ? store[0][1:0] : 2'h0;
            vco_cap_count <= store[retimer_channel_pkg::STORE_COUNT - 1]
                                  [retimer_channel_pkg::VCO_CAP_OV_BIT]
                             ? vco_cap_override_value : vco_cap_internal;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_CLOCK_STOP: assert property (
        control[7] |=> core_clock_disable && all_sm_reset && core_sm_reset)
        else $error("Core clock not stopped with full reset.");
    AST_CORE_RESET: assert property (
        control[3] |=> core_sm_reset)
        else $error("Core state machine reset missing.");
    AST_REGS_DEFAULT: assert property (
        control[2] |=> control == 8'h00 && store[0] == 8'h00 && store[5] == 8'h60)
        else $error("Registers not restored to defaults.");
    AST_COUNTERS: assert property (
        control[1] && !control[0] |=> freq_offset_counter_reset && eye_monitor_counter_reset
                                      && lock_detect_counter_reset && band_tune_counter_reset)
        else $error("Counter group reset missing.");
    AST_FREQ_ONLY: assert property (
        control[0] && !control[1] |=> freq_offset_counter_reset && !eye_monitor_counter_reset)
        else $error("Frequency counter reset wrong.");
    AST_STATUS_READ: assert property (
        status_read && !regs_reset |=> reg_rdata[7] == $past(signal_present)
                                       && reg_rdata[6] == $past(polarity_inverted_flag)
                                       && reg_rdata[4:1] == $past(link_status[4:1]))
        else $error("Status read mismatch.");
    AST_LOCK_LOSS_SET: assert property (
        $fell(cdr_locked) && u_lock_loss.acquired && !regs_reset |=> lock_loss_flag)
        else $error("Lock loss flag not set.");
    AST_LOCK_LOSS_CLEAR: assert property (
        status_read && !u_lock_loss.lost |=> !lock_loss_flag)
        else $error("Lock loss flag not cleared by read.");
    AST_SIGNAL_LOSS: assert property (
        !u_signal_loss.acquired |-> !signal_loss_flag)
        else $error("Signal loss set without acquisition.");
    AST_SIGNAL_LOSS_SET: assert property (
        $fell(signal_present) && u_signal_loss.acquired && !regs_reset |=> signal_loss_flag)
        else $error("Signal loss flag not set.");
    AST_VIEW: assert property (
        access_read && reg_addr == 8'h02 |=> reg_rdata == $past(pick_word(status_words,
                                                                   status_view_select)))
        else $error("Status view mux wrong.");
    AST_BOOST: assert property (
        !eq_force_enable |=> !eq_boost_forced && eq_stage_a_boost == 2'h0
                             && eq_stage_b_boost == 2'h0 && eq_stage_c_boost == 2'h0
                             && eq_stage_d_boost == 2'h0)
        else $error("Boost applied without force enable.");
    AST_VCO: assert property (
        store[6][7] |=> vco_cap_count == $past(vco_cap_override_value))
        else $error("VCO override not applied.");
    AST_PAGE: assert property (
        reg_read && !selected |=> !reg_rdata_valid)
        else $error("Access answered while channel not selected.");

    COV_LOCK_LOSS: cover property (cdr_locked ##1 !cdr_locked ##1 lock_loss_flag);
    COV_REGS_RESET: cover property (access_write && reg_addr == 8'h00 && reg_wdata[2]);
    COV_VIEW_READ: cover property (access_read && reg_addr == 8'h02);
endmodule
`default_nettype wire

// file: tb/mgmt_host_model.sv
// Management host model that drives the channel register access port.
`timescale 1ns/1ns
`default_nettype none
module mgmt_host_model
(
    // Clock.
    input  wire logic        clk,
    // Register access port.
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        reg_rdata_valid,
    output logic      [7:0]  reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic             reg_write,
    output logic             reg_read,
    // Page selection.
    output logic             channel_page_select,
    output logic      [15:0] channel_enable
);
    // Idle values until the bench opens the channel page.
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        channel_page_select = 1'b0;
        channel_enable = 16'h0000;
    end

    task automatic select_page(input logic on, input logic [15:0] en);
        @(negedge clk);
        channel_page_select = on;
        channel_enable = en;
    endtask

    // One-cycle write pulse; data is scrambled once released so nothing relies on it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        reg_wdata = ~d;
    endtask

    // One-cycle read pulse; the answer arrives in the following cycle, and the data then holds until the next accepted read.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic got);
        @(negedge clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk);
        reg_read = 1'b0;
        got = reg_rdata_valid;
        d = reg_rdata;
    endtask

    task automatic rmw(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] bits);
        logic [7:0] cur;
        logic       got;
        rd(a, cur, got);
        wr(a, (cur & ~mask) | (bits & mask));
    endtask
endmodule
`default_nettype wire

// file: tb/retimer_channel_ctrl_status_regs_tb.sv
// Self-checking bench for the retimer channel control and status registers.
`timescale 1ns/1ns
`default_nettype none
module retimer_channel_ctrl_status_regs_tb;
    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata;
    logic         reg_write, reg_read, reg_rdata_valid, page_sel;
    logic [15:0]  ch_en;
    logic         sig = 1'b0, pol = 1'b0, cdr = 1'b0, force_en = 1'b0;
    logic [3:0]   prbs_lk = 4'h0, view = 4'h0;
    logic [127:0] words;
    logic [4:0]   vco_int = 5'h0A, vco_ov = 5'h15, vco_cnt;
    logic         forced, ccd, core_rst, all_rst, fo_rst, eye_rst, ld_rst, bt_rst;
    logic [1:0]   bst_a, bst_b, bst_c, bst_d;
    logic [7:0]   ctl_outs, rst_tab [10];
    int           error_cnt = 0;
    int           checks_done = 0;
    logic [7:0]   ctl_wr [5] = '{8'h80, 8'h08, 8'h02, 8'h01, 8'h00};
    logic [7:0]   ctl_exp [5] = '{8'h70, 8'h20, 8'h0F, 8'h08, 8'h00};

    // Clock of 10 ns and a compact view of the control outputs.
    always #5 clk = ~clk;
    assign ctl_outs = {1'b0, ccd, core_rst, all_rst, fo_rst, eye_rst, ld_rst, bt_rst};

    mgmt_host_model u_mgmt_host_model (.clk(clk), .reg_rdata(reg_rdata),
        .reg_rdata_valid(reg_rdata_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .channel_page_select(page_sel),
        .channel_enable(ch_en));

    retimer_channel_ctrl_status_regs u_retimer_channel_ctrl_status_regs (.clk(clk),
        .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .channel_page_select(page_sel), .channel_enable(ch_en), .signal_present(sig),
        .polarity_inverted_flag(pol), .cdr_locked(cdr), .prbs31_locked(prbs_lk[3]),
        .prbs15_locked(prbs_lk[2]), .prbs9_locked(prbs_lk[1]), .prbs7_locked(prbs_lk[0]),
        .status_view_select(view), .status_words(words), .eq_force_enable(force_en),
        .eq_boost_forced(forced), .eq_stage_a_boost(bst_a), .eq_stage_b_boost(bst_b),
        .eq_stage_c_boost(bst_c), .eq_stage_d_boost(bst_d), .vco_cap_internal(vco_int),
        .vco_cap_override_value(vco_ov), .vco_cap_count(vco_cnt),
        .core_clock_disable(ccd), .core_sm_reset(core_rst), .all_sm_reset(all_rst),
        .freq_offset_counter_reset(fo_rst), .eye_monitor_counter_reset(eye_rst),
        .lock_detect_counter_reset(ld_rst), .band_tune_counter_reset(bt_rst));

    // Compares one value and counts the outcome.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask

    // Reads one register and expects both the answer pulse and the value.
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       got;
        u_mgmt_host_model.rd(a, d, got);
        check({7'h00, got}, 8'h01);
        check(d, exp);
    endtask

    // Lets the register and then the derived outputs settle.
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Cuts a hang short.
    initial
    begin
        #500000;
        error_cnt++;
        finish_test();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [7:0] d;
        logic       got;
        for (int n = 0; n < 16; n++)
            words[8*n +: 8] = 8'hA5 ^ 8'(n * 8'h11);
        rst_tab = '{8'h00, 8'h00, 8'hA5, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h60, 8'h00};
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        u_mgmt_host_model.select_page(1'b1, 16'h0001);
        for (int a = 0; a < 10; a++)
            rd_check(8'(a), rst_tab[a]); // reset values
        rd_check(8'h0A, 8'h00); // unmapped offset
        for (int i = 0; i < 5; i++)
        begin
            u_mgmt_host_model.wr(8'h00, ctl_wr[i]);
            settle();
            check(ctl_outs, ctl_exp[i]); // control table
        end
        sig = 1'b1;
        pol = 1'b1;
        cdr = 1'b1;
        settle();
        rd_check(8'h01, 8'hC0); // present and inverted
        pol = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            prbs_lk = 4'h1 << i;
            settle();
            rd_check(8'h01, {3'h4, prbs_lk, 1'b0}); // sequence locks
        end
        prbs_lk = 4'h0;
        sig = 1'b0;
        cdr = 1'b0;
        settle();
        rd_check(8'h01, 8'h21); // loss flags set
        rd_check(8'h01, 8'h00); // cleared by read
        for (int n = 0; n < 16; n++)
        begin
            view = 4'(n);
            rd_check(8'h02, words[8*n +: 8]); // selected word
        end
        u_mgmt_host_model.wr(8'h03, 8'hE4);
        settle();
        check({bst_a, bst_b, bst_c, bst_d}, 8'h00); // not forced
        force_en = 1'b1;
        repeat (3) @(negedge clk);
        check({bst_a, bst_b, bst_c, bst_d}, 8'hE4); // stage values forced
        check({7'h00, forced}, 8'h01); // force flag
        u_mgmt_host_model.wr(8'h09, 8'h80);
        settle();
        check({3'h0, vco_cnt}, 8'h15); // override applied
        u_mgmt_host_model.wr(8'h09, 8'h00);
        settle();
        check({3'h0, vco_cnt}, 8'h0A); // internal count
        u_mgmt_host_model.select_page(1'b1, 16'h0002);
        u_mgmt_host_model.wr(8'h03, 8'h55);
        u_mgmt_host_model.rd(8'h03, d, got);
        check({7'h00, got}, 8'h00); // other channel selected
        u_mgmt_host_model.select_page(1'b0, 16'h0001);
        u_mgmt_host_model.wr(8'h03, 8'h55);
        u_mgmt_host_model.select_page(1'b1, 16'h0001);
        rd_check(8'h03, 8'hE4); // refused writes left no trace
        u_mgmt_host_model.rmw(8'h05, 8'hF0, 8'hA0);
        rd_check(8'h05, 8'hA1); // low bits kept
        u_mgmt_host_model.wr(8'h00, 8'h04);
        settle();
        rd_check(8'h05, 8'h01); // restored reserved
        rd_check(8'h03, 8'h00); // restored boost
        rd_check(8'h00, 8'h00); // control self-clears
        finish_test();
    end
endmodule
`default_nettype wire
